/* src/tob_regs.svh */
`ifndef TOB_REGS_SVH
`define TOB_REGS_SVH

// Object indices
`define TOB_IDX_TORQUE_DEMAND 16'h6074
`define TOB_IDX_TORQUE_ACTUAL 16'h6077
`define TOB_IDX_CURRENT_FILT 16'h6078
`define TOB_IDX_DC_LINK_VOLT 16'h6079
`define TOB_IDX_POS_LIMIT 16'h60e0
`define TOB_IDX_NEG_LIMIT 16'h60e1

// Limit range and reset value, percent of rated current
`define TOB_LIMIT_MAX 16'h0064
`define TOB_LIMIT_RST 16'h0064
// Percent to per-thousand scale factor
`define TOB_LIMIT_SCALE 17'h0000a

// Abort codes
`define TOB_ABORT_NONE 32'h00000000
`define TOB_ABORT_RANGE 32'h06040030
`define TOB_ABORT_READ_ONLY 32'h06010002
`define TOB_ABORT_NO_OBJECT 32'h06020000

// Emergency codes for bad limits at initialization
`define TOB_EMCY_POS_LIMIT 16'h8b23
`define TOB_EMCY_NEG_LIMIT 16'h8b24

`endif

/* src/tob_pkg.sv */
package tob_pkg;

    // State of the object bank, all but the two reset synchronizer flops
    typedef struct packed {
        logic        rsp_valid;
        logic [31:0] rsp_abort;
        logic [31:0] rsp_data;
        logic [15:0] pos_lim;
        logic [15:0] neg_lim;
        logic        emcy_valid;
        logic [15:0] emcy_code;
        logic        emcy_neg_pend;
        logic [15:0] torque_lim;
        logic        pos_quad;
    } tob_state_t;

endpackage : tob_pkg

/* src/tob_torque_object_bank.sv */
`include "tob_regs.svh"

// Functional notes
// - Torque demand readable as signed 16-bit, read-only, no process data.
// - Actual torque readable as signed 16-bit, read-only, process-data mappable.
// - Filtered motor current readable as signed 16-bit, read-only.
// - DC link voltage in millivolts readable as unsigned 32-bit, read-only.
// - Positive torque limit, 0 to 100 percent, resets to 100.
// - Positive limit bounds motoring at positive or regenerating at negative speed.
// - Negative torque limit, 0 to 100 percent, resets to 100.
// - Negative limit bounds motoring at negative or regenerating at positive speed.
// - Out-of-range limit write is refused with the range abort code.
// - Bad limit at initialization sends emergency 0x8B23 or 0x8B24.
// - Limits live in volatile storage only, never saved.
// - Limits also act while running the velocity profile.
module tob_torque_object_bank
    import tob_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [15:0] i_req_index,
    input wire logic [31:0] i_req_data,
    input wire logic signed [15:0] i_torque_demand,
    input wire logic signed [15:0] i_torque_actual,
    input wire logic signed [15:0] i_current_filt,
    input wire logic [31:0] i_dc_link_mv,
    input wire logic i_init_load,
    input wire logic [15:0] i_init_pos_lim,
    input wire logic [15:0] i_init_neg_lim,
    input wire logic signed [15:0] i_torque_cmd,
    input wire logic i_vel_neg,
    input wire logic i_regen,
    output logic o_rsp_valid,
    output logic [31:0] o_rsp_abort,
    output logic [31:0] o_rsp_data,
    output logic [15:0] o_pos_limit,
    output logic [15:0] o_neg_limit,
    output logic o_emcy_valid,
    output logic [15:0] o_emcy_code,
    output logic signed [15:0] o_torque_limited,
    output logic o_pos_quadrant
);

    // Percent limit to per-thousand bound, 17 bits to hold 1000 safely
    function automatic logic signed [16:0] lim_scale(input logic [15:0] lim);
        logic [16:0] prod;
        prod = 17'(lim) * `TOB_LIMIT_SCALE;
        return $signed(prod);
    endfunction : lim_scale

    function automatic logic lim_ok(input logic [15:0] lim);
        return lim <= `TOB_LIMIT_MAX;
    endfunction : lim_ok

    logic [1:0] rst_sync_q;
    logic rst_n;
    tob_state_t st_q;
    tob_state_t st_d;
    logic signed [16:0] cmd_ext;
    logic signed [16:0] pos_bound;
    logic signed [16:0] neg_bound;

    // Reset released through two flops so deassertion is clean
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Bounds derived from the held limits
    assign cmd_ext = 17'(i_torque_cmd);
    assign pos_bound = lim_scale(st_q.pos_lim);
    assign neg_bound = -lim_scale(st_q.neg_lim);

    // Next-state logic
    always_comb
    begin
        st_d = st_q;
        st_d.rsp_valid = 1'b0;
        st_d.emcy_valid = 1'b0;
        // Object access, one answer per request, one cycle later
        if (i_req_valid)
        begin
            st_d.rsp_valid = 1'b1;
            st_d.rsp_abort = `TOB_ABORT_NONE;
            st_d.rsp_data = 32'h00000000;
            unique case (i_req_index)
                `TOB_IDX_TORQUE_DEMAND,
                `TOB_IDX_TORQUE_ACTUAL,
                `TOB_IDX_CURRENT_FILT,
                `TOB_IDX_DC_LINK_VOLT:
                begin
                    if (i_req_write)
                    begin
                        // Measured values are never overwritten
                        st_d.rsp_abort = `TOB_ABORT_READ_ONLY;
                    end
                    else if (i_req_index == `TOB_IDX_TORQUE_DEMAND)
                    begin
                        st_d.rsp_data = 32'(i_torque_demand);
                    end
                    else if (i_req_index == `TOB_IDX_TORQUE_ACTUAL)
                    begin
                        st_d.rsp_data = 32'(i_torque_actual);
                    end
                    else if (i_req_index == `TOB_IDX_CURRENT_FILT)
                    begin
                        st_d.rsp_data = 32'(i_current_filt);
                    end
                    else
                    begin
                        st_d.rsp_data = i_dc_link_mv;
                    end
                end
                `TOB_IDX_POS_LIMIT,
                `TOB_IDX_NEG_LIMIT:
                begin
                    if (!i_req_write)
                    begin
                        st_d.rsp_data = (i_req_index == `TOB_IDX_POS_LIMIT) ?
                            {16'h0000, st_q.pos_lim} : {16'h0000, st_q.neg_lim};
                    end
                    else if (i_req_data[31:16] != 16'h0000 || !lim_ok(i_req_data[15:0]))
                    begin
                        // Upper half counts too, so 0x10064 is not taken as 100
                        st_d.rsp_abort = `TOB_ABORT_RANGE;
                    end
                    else if (i_req_index == `TOB_IDX_POS_LIMIT)
                    begin
                        st_d.pos_lim = i_req_data[15:0];
                    end
                    else
                    begin
                        st_d.neg_lim = i_req_data[15:0];
                    end
                end
                default:
                begin
                    st_d.rsp_abort = `TOB_ABORT_NO_OBJECT;
                end
            endcase
        end
        // Initial limits: good values load, bad ones keep the old value and report
        if (st_q.emcy_neg_pend)
        begin
            st_d.emcy_valid = 1'b1;
            st_d.emcy_code = `TOB_EMCY_NEG_LIMIT;
            st_d.emcy_neg_pend = 1'b0;
        end
        if (i_init_load)
        begin
            if (lim_ok(i_init_pos_lim))
            begin
                st_d.pos_lim = i_init_pos_lim;
            end
            if (lim_ok(i_init_neg_lim))
            begin
                st_d.neg_lim = i_init_neg_lim;
            end
            if (!lim_ok(i_init_pos_lim))
            begin
                // Both bad: positive goes first, negative one cycle later
                st_d.emcy_valid = 1'b1;
                st_d.emcy_code = `TOB_EMCY_POS_LIMIT;
                st_d.emcy_neg_pend = !lim_ok(i_init_neg_lim);
            end
            else if (!lim_ok(i_init_neg_lim))
            begin
                st_d.emcy_valid = 1'b1;
                st_d.emcy_code = `TOB_EMCY_NEG_LIMIT;
            end
        end
        // Quadrant: positive torque when motoring forward or braking reverse
        st_d.pos_quad = (!i_regen && !i_vel_neg) || (i_regen && i_vel_neg);
        // Clamp runs in every profile, velocity included
        if (cmd_ext > pos_bound)
        begin
            st_d.torque_lim = pos_bound[15:0];
        end
        else if (cmd_ext < neg_bound)
        begin
            st_d.torque_lim = neg_bound[15:0];
        end
        else
        begin
            st_d.torque_lim = i_torque_cmd;
        end
    end

    // State register; limits restart at full range, nothing is persisted
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '{rsp_valid: 1'b0, rsp_abort: `TOB_ABORT_NONE, rsp_data: 32'h00000000,
                      pos_lim: `TOB_LIMIT_RST, neg_lim: `TOB_LIMIT_RST,
                      emcy_valid: 1'b0, emcy_code: 16'h0000, emcy_neg_pend: 1'b0,
                      torque_lim: 16'h0000, pos_quad: 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state flops
    assign o_rsp_valid = st_q.rsp_valid;
    assign o_rsp_abort = st_q.rsp_abort;
    assign o_rsp_data = st_q.rsp_data;
    assign o_pos_limit = st_q.pos_lim;
    assign o_neg_limit = st_q.neg_lim;
    assign o_emcy_valid = st_q.emcy_valid;
    assign o_emcy_code = st_q.emcy_code;
    assign o_torque_limited = st_q.torque_lim;
    assign o_pos_quadrant = st_q.pos_quad;

    // Checks
    logic wr_pos;
    logic wr_neg;
    assign wr_pos = i_req_valid && i_req_write && i_req_index == `TOB_IDX_POS_LIMIT;
    assign wr_neg = i_req_valid && i_req_write && i_req_index == `TOB_IDX_NEG_LIMIT;

    property p_read_demand;
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_req_valid && !i_req_write && i_req_index == `TOB_IDX_TORQUE_DEMAND
        |=> o_rsp_valid && o_rsp_data == 32'($past(i_torque_demand));
    endproperty
    a_read_demand: assert property (p_read_demand) else $error("demand read wrong");

    property p_read_actual;
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_req_valid && !i_req_write && i_req_index == `TOB_IDX_TORQUE_ACTUAL
        |=> o_rsp_data == 32'($past(i_torque_actual)) && o_rsp_abort == `TOB_ABORT_NONE;
    endproperty
    a_read_actual: assert property (p_read_actual) else $error("actual read wrong");

    property p_read_filt;
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_req_valid && !i_req_write && i_req_index == `TOB_IDX_CURRENT_FILT
        |=> o_rsp_data == 32'($past(i_current_filt));
    endproperty
    a_read_filt: assert property (p_read_filt) else $error("current read wrong");

    property p_read_dc;
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_req_valid && !i_req_write && i_req_index == `TOB_IDX_DC_LINK_VOLT
        |=> o_rsp_data == $past(i_dc_link_mv);
    endproperty
    a_read_dc: assert property (p_read_dc) else $error("dc link read wrong");

    property p_pos_write;
        @(posedge i_clk_sys) disable iff (!rst_n)
        wr_pos && i_req_data <= 32'(`TOB_LIMIT_MAX) && !i_init_load
        |=> o_pos_limit == $past(i_req_data[15:0]) && o_rsp_abort == `TOB_ABORT_NONE;
    endproperty
    a_pos_write: assert property (p_pos_write) else $error("pos limit not taken");

    property p_neg_write;
        @(posedge i_clk_sys) disable iff (!rst_n)
        wr_neg && i_req_data <= 32'(`TOB_LIMIT_MAX) && !i_init_load
        |=> o_neg_limit == $past(i_req_data[15:0]);
    endproperty
    a_neg_write: assert property (p_neg_write) else $error("neg limit not taken");

    property p_range_abort;
        @(posedge i_clk_sys) disable iff (!rst_n)
        (wr_pos || wr_neg) && i_req_data > 32'(`TOB_LIMIT_MAX) && !i_init_load
        |=> o_rsp_abort == `TOB_ABORT_RANGE && $stable(o_pos_limit) && $stable(o_neg_limit);
    endproperty
    a_range_abort: assert property (p_range_abort) else $error("range abort missing");

    property p_emcy_pos;
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_init_load && i_init_pos_lim > `TOB_LIMIT_MAX
        |=> o_emcy_valid && o_emcy_code == `TOB_EMCY_POS_LIMIT && $stable(o_pos_limit);
    endproperty
    a_emcy_pos: assert property (p_emcy_pos) else $error("pos emergency missing");

    property p_emcy_neg;
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_init_load && i_init_neg_lim > `TOB_LIMIT_MAX
        |-> ##[1:2] o_emcy_valid && o_emcy_code == `TOB_EMCY_NEG_LIMIT;
    endproperty
    a_emcy_neg: assert property (p_emcy_neg) else $error("neg emergency missing");

    property p_lim_hold;
        @(posedge i_clk_sys) disable iff (!rst_n)
        !wr_pos && !wr_neg && !i_init_load |=> $stable(o_pos_limit) && $stable(o_neg_limit);
    endproperty
    a_lim_hold: assert property (p_lim_hold) else $error("limit changed unasked");

    property p_clamp;
        @(posedge i_clk_sys) disable iff (!rst_n)
        17'(o_torque_limited) <= lim_scale($past(o_pos_limit))
        && 17'(o_torque_limited) >= -lim_scale($past(o_neg_limit));
    endproperty
    a_clamp: assert property (p_clamp) else $error("torque beyond limit");

    // All four measured objects, named one by one so neighbouring indices stay out
    property p_ro_write;
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_req_valid && i_req_write && (i_req_index == `TOB_IDX_TORQUE_DEMAND
        || i_req_index == `TOB_IDX_TORQUE_ACTUAL || i_req_index == `TOB_IDX_CURRENT_FILT
        || i_req_index == `TOB_IDX_DC_LINK_VOLT)
        |=> o_rsp_valid && o_rsp_abort == `TOB_ABORT_READ_ONLY && o_rsp_data == 32'h00000000;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");

    c_range: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
        o_rsp_abort == `TOB_ABORT_RANGE && o_rsp_valid);
    c_both_emcy: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
        o_emcy_code == `TOB_EMCY_POS_LIMIT && o_emcy_valid ##1 o_emcy_valid);
    c_clamped: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
        o_torque_limited != $past(i_torque_cmd));

endmodule : tob_torque_object_bank

/* testbench/tob_master_model.sv */
// Network master side: issues one object access at a time
module tob_master_model (
    input wire logic i_clk_sys,
    input wire logic i_rsp_valid,
    input wire logic [31:0] i_rsp_abort,
    input wire logic [31:0] i_rsp_data,
    output logic o_req_valid,
    output logic o_req_write,
    output logic [15:0] o_req_index,
    output logic [31:0] o_req_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Objects of the save sequence; the signature value is arbitrary
    localparam logic [15:0] IDX_PROFILE_TYPE = 16'h6088;
    localparam logic [15:0] IDX_STORE = 16'h1010;
    localparam logic [31:0] SAVE_SIG = 32'h00000001;

    // Idle bus at time zero
    initial
    begin
        o_req_valid = 1'b0;
        o_req_write = 1'b0;
        o_req_index = 16'h0000;
        o_req_data = 32'h00000000;
    end

    // One object access; the answer is taken in the cycle it stands
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] dat,
        output logic [31:0] abort, output logic [31:0] rdat, output bit ok);
        int n;
        @(posedge i_clk_sys);
        o_req_valid <= 1'b1;
        o_req_write <= wr;
        o_req_index <= idx;
        o_req_data <= dat;
        @(posedge i_clk_sys);
        o_req_valid <= 1'b0;
        // Scrambled qualifiers expose a bank that ignores valid
        o_req_index <= ~idx;
        o_req_data <= ~dat;
        for (n = 0; n < 4; n++)
        begin
            #1;
            if (i_rsp_valid === 1'b1)
                break;
            @(posedge i_clk_sys);
        end
        ok = (n == 0);
        abort = i_rsp_abort;
        rdat = i_rsp_data;
    endtask : xfer

    // Save sequence: new value first, then the signature; node reset is the caller's
    task automatic store_seq(input logic [31:0] val, output logic [31:0] ab_val,
        output logic [31:0] ab_sig, output bit ok);
        logic [31:0] rd;
        bit ok_val;
        xfer(1'b1, IDX_PROFILE_TYPE, val, ab_val, rd, ok_val);
        xfer(1'b1, IDX_STORE, SAVE_SIG, ab_sig, rd, ok);
        ok = ok && ok_val;
    endtask : store_seq
endmodule : tob_master_model

/* testbench/tob_torque_object_bank_tb.sv */
`include "tob_regs.svh"

module tob_torque_object_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic wr;
        logic [15:0] idx;
        logic [31:0] dat;
        logic [31:0] ab;
        logic [31:0] rd;
    } tob_row_t;

    logic clk = 1'b0, rst_n = 1'b0, req_valid, req_write, init_load = 1'b0;
    logic [15:0] req_index, init_pos = 16'h0000, init_neg = 16'h0000;
    logic [31:0] req_data, rsp_abort, rsp_data;
    logic rsp_valid, emcy_valid, pos_quad, vel_neg = 1'b0, regen = 1'b0;
    logic [15:0] pos_lim, neg_lim, emcy_code;
    logic signed [15:0] torque_lim, torque_cmd = 16'sd0;
    int err_count = 0, compares = 0;
    logic [31:0] st_ab0, st_ab1;
    bit st_ok;
    // Row order matters: later rows see limits left by earlier writes
    tob_row_t rows [16] = '{
        '{1'b0, `TOB_IDX_TORQUE_DEMAND, 32'h0, `TOB_ABORT_NONE, 32'hfffffffb},
        '{1'b0, `TOB_IDX_TORQUE_ACTUAL, 32'h0, `TOB_ABORT_NONE, 32'h00001234},
        '{1'b0, `TOB_IDX_CURRENT_FILT, 32'h0, `TOB_ABORT_NONE, 32'hffff8000},
        '{1'b0, `TOB_IDX_DC_LINK_VOLT, 32'h0, `TOB_ABORT_NONE, 32'hdeadbeef},
        '{1'b0, `TOB_IDX_POS_LIMIT, 32'h0, `TOB_ABORT_NONE, 32'h00000064},
        '{1'b0, `TOB_IDX_NEG_LIMIT, 32'h0, `TOB_ABORT_NONE, 32'h00000064},
        '{1'b1, `TOB_IDX_TORQUE_DEMAND, 32'h1, `TOB_ABORT_READ_ONLY, 32'h0},
        '{1'b1, `TOB_IDX_TORQUE_ACTUAL, 32'h1, `TOB_ABORT_READ_ONLY, 32'h0},
        '{1'b1, `TOB_IDX_CURRENT_FILT, 32'h1, `TOB_ABORT_READ_ONLY, 32'h0},
        '{1'b1, `TOB_IDX_DC_LINK_VOLT, 32'h1, `TOB_ABORT_READ_ONLY, 32'h0},
        '{1'b1, `TOB_IDX_POS_LIMIT, 32'h65, `TOB_ABORT_RANGE, 32'h0},
        '{1'b1, `TOB_IDX_NEG_LIMIT, 32'h10000, `TOB_ABORT_RANGE, 32'h0},
        '{1'b1, `TOB_IDX_POS_LIMIT, 32'h0, `TOB_ABORT_NONE, 32'h0},
        '{1'b0, `TOB_IDX_POS_LIMIT, 32'h0, `TOB_ABORT_NONE, 32'h0},
        '{1'b0, 16'h1234, 32'h0, `TOB_ABORT_NO_OBJECT, 32'h0},
        '{1'b0, `TOB_IDX_TORQUE_DEMAND, 32'h0, `TOB_ABORT_NONE, 32'hfffffffb}};
    logic signed [15:0] cmds [4] = '{16'sd900, -16'sd900, 16'sd200, -16'sd200};
    logic signed [15:0] exps [4] = '{16'sd500, -16'sd300, 16'sd200, -16'sd200};

    tob_torque_object_bank u_tob_torque_object_bank (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_req_valid(req_valid), .i_req_write(req_write), .i_req_index(req_index),
        .i_req_data(req_data), .i_torque_demand(-16'sd5), .i_torque_actual(16'h1234),
        .i_current_filt(16'h8000), .i_dc_link_mv(32'hdeadbeef), .i_init_load(init_load),
        .i_init_pos_lim(init_pos), .i_init_neg_lim(init_neg), .i_torque_cmd(torque_cmd),
        .i_vel_neg(vel_neg), .i_regen(regen), .o_rsp_valid(rsp_valid),
        .o_rsp_abort(rsp_abort), .o_rsp_data(rsp_data), .o_pos_limit(pos_lim),
        .o_neg_limit(neg_lim), .o_emcy_valid(emcy_valid), .o_emcy_code(emcy_code),
        .o_torque_limited(torque_lim), .o_pos_quadrant(pos_quad));

    tob_master_model u_tob_master_model (.i_clk_sys(clk), .i_rsp_valid(rsp_valid),
        .i_rsp_abort(rsp_abort), .i_rsp_data(rsp_data), .o_req_valid(req_valid),
        .o_req_write(req_write), .o_req_index(req_index), .o_req_data(req_data));

    // Free-running system clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Access through the master; a late answer ends the run
    task automatic acc(input tob_row_t r);
        logic [31:0] ab, rd;
        bit ok;
        u_tob_master_model.xfer(r.wr, r.idx, r.dat, ab, rd, ok);
        if (!ok)
        begin
            err_count++;
            $display("[ERR] rsp_valid expected 1 seen timeout");
            close_out();
        end
        else
        begin
            chk("abort", r.ab, ab);
            if (r.wr || r.ab == `TOB_ABORT_NONE)
                chk("data", r.rd, rd);
        end
    endtask : acc

    // Startup limit pulse; returns just after the taking edge
    task automatic load(input logic [15:0] p, input logic [15:0] n);
        @(posedge clk);
        init_load <= 1'b1;
        init_pos <= p;
        init_neg <= n;
        @(posedge clk);
        init_load <= 1'b0;
        #1;
    endtask : load

    // Main sequence
    initial
    begin
        repeat (11) @(posedge clk);
        #1;
        chk("pos_lim rst", 32'h64, pos_lim);
        chk("neg_lim rst", 32'h64, neg_lim);
        chk("rsp_valid rst", 32'h0, rsp_valid);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i])
            acc(rows[i]);
        acc('{1'b1, `TOB_IDX_POS_LIMIT, 32'd50, `TOB_ABORT_NONE, 32'h0});
        chk("pos_lim", 32'd50, pos_lim);
        acc('{1'b1, `TOB_IDX_NEG_LIMIT, 32'd30, `TOB_ABORT_NONE, 32'h0});
        chk("neg_lim", 32'd30, neg_lim);
        // All four quadrants, clamp by torque sign against 50 and 30 percent
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            torque_cmd <= cmds[k];
            regen <= k[0];
            vel_neg <= k[0] ^ k[1];
            @(posedge clk);
            #1;
            chk("torque_lim", 32'(exps[k]), 32'(torque_lim));
            chk("pos_quad", 32'(k < 2), 32'(pos_quad));
        end
        load(16'd200, 16'd40);
        chk("emcy_valid", 32'h1, emcy_valid);
        chk("emcy_code", 32'h8b23, emcy_code);
        chk("pos_lim keep", 32'd50, pos_lim);
        chk("neg_lim load", 32'd40, neg_lim);
        load(16'd101, 16'd150);
        chk("emcy_code pos", 32'h8b23, emcy_code);
        @(posedge clk);
        #1;
        chk("emcy_valid neg", 32'h1, emcy_valid);
        chk("emcy_code neg", 32'h8b24, emcy_code);
        chk("neg_lim keep", 32'd40, neg_lim);
        load(16'd20, 16'd100);
        chk("emcy_valid good", 32'h0, emcy_valid);
        chk("pos_lim load", 32'd20, pos_lim);
        // Master saves, then resets the node; the bank has nothing to store into
        u_tob_master_model.store_seq(32'h0, st_ab0, st_ab1, st_ok);
        chk("store answers", 32'h1, 32'(st_ok));
        chk("store value abort", `TOB_ABORT_NO_OBJECT, st_ab0);
        chk("store sig abort", `TOB_ABORT_NO_OBJECT, st_ab1);
        // A reset loses run-time limits: nothing is kept across it
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        chk("pos_lim volatile", 32'h64, pos_lim);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        acc(rows[4]);
        close_out();
    end
endmodule : tob_torque_object_bank_tb
